// File: verilog/mode_defs.svh
`ifndef MODE_DEFS_SVH
`define MODE_DEFS_SVH

// Clock and timing
`define CLK_HZ 40000000
`define LOSS_TIME_S 30
`define LOSS_CYCLES (`LOSS_TIME_S * `CLK_HZ)
`define FLASH_HALF_MS 500
`define FLASH_CYCLES (`FLASH_HALF_MS * (`CLK_HZ / 1000))

// Register byte offsets
`define ADR_MODE 8'h00
`define ADR_SESSION 8'h04
`define ADR_FORCE 8'h08
`define ADR_STATUS 8'h0C

// Mode request and readback codes
`define CODE_INIT 3'h0
`define CODE_PROGRAM 3'h1
`define CODE_RUN 3'h2
`define CODE_DBG_STOP 3'h3
`define CODE_DBG_RUN 3'h4
`define CODE_RESTORE 3'h5

// Field positions
`define SES_OPEN_BIT 0
`define SES_CLOSE_BIT 1
`define SES_REFUSED_BIT 1
`define FRC_REQ_BIT 0
`define FRC_REJECT_BIT 1
`define ST_COMM_BIT 4
`define ST_EXEC_BIT 5
`define ST_RUNLED_BIT 6
`define ST_DBGLED_BIT 7
`define ST_LOSS_BIT 8
`define ST_CLR_REFUSED_BIT 0
`define ST_CLR_REJECT_BIT 1

// Widths and reset values
`define IO_WIDTH 16
`define IO_RESET 16'h0000
`define DATA_RESET 32'h0000_0000

`endif

// File: verilog/mode_pkg.sv
package mode_pkg;
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_PROGRAM,
    MODE_RUN,
    MODE_DBG_STOP,
    MODE_DBG_RUN,
    MODE_RESTORE
  } mode_e;
endpackage

// File: verilog/loss_timer.sv
`timescale 1ns/1ps
`include "mode_defs.svh"

// Counts while the tool session is missing in debug; holds expired until disarmed
module loss_timer #(
  parameter int unsigned LOSS_CYCLES = `LOSS_CYCLES
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic arm,
  output logic expired
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;

  // Count up while armed until expired, restart from zero whenever disarmed
  always_comb
  begin
    cnt_next = 32'h0000_0000;
    if (arm && !expired)
    begin
      cnt_next = cnt_reg + 32'h0000_0001;
    end
    else if (arm)
    begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cnt_reg <= 32'h0000_0000;
    else
      cnt_reg <= cnt_next;
  end

  assign expired = (cnt_reg >= (LOSS_CYCLES - 32'd1));
endmodule

// File: verilog/indicator_drv.sv
`timescale 1ns/1ps
`include "mode_defs.svh"

// Drives one indicator: steady, flashing or dark
module indicator_drv #(
  parameter int unsigned FLASH_CYCLES = `FLASH_CYCLES
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic steady,
  input wire logic flash,
  output logic led
);
  logic [31:0] div_reg;
  logic [31:0] div_next;
  logic phase_reg;
  logic phase_next;

  // Free-running half-period divider so all flashing indicators share a rhythm
  always_comb
  begin
    div_next = div_reg + 32'h0000_0001;
    phase_next = phase_reg;
    if (div_reg >= (FLASH_CYCLES - 32'd1))
    begin
      div_next = 32'h0000_0000;
      phase_next = !phase_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      div_reg <= 32'h0000_0000;
      phase_reg <= 1'b1;
    end
    else
    begin
      div_reg <= div_next;
      phase_reg <= phase_next;
    end
  end

  assign led = steady | (flash & phase_reg);
endmodule

// File: verilog/safety_mode_ctrl.sv
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "mode_defs.svh"

module safety_mode_ctrl
  import mode_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = `LOSS_CYCLES,
  parameter int unsigned FLASH_CYCLES = `FLASH_CYCLES
)(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  input wire logic TOOL_LINK,
  input wire logic SELFTEST_DONE,
  input wire logic PROG_VALID,
  input wire logic [15:0] SAFE_IN,
  input wire logic [15:0] STD_IN,
  input wire logic [15:0] PROG_SAFE_OUT,
  input wire logic [15:0] PROG_STD_OUT,
  output logic [15:0] SAFE_IN_DATA,
  output logic [15:0] STD_IN_DATA,
  output logic [15:0] SAFE_OUT,
  output logic [15:0] STD_OUT,
  output logic [15:0] STATUS_WORD,
  output logic SELFTEST_RUN,
  output logic COMM_ACTIVE,
  output logic PROG_EXEC,
  output logic FORCE_EN,
  output logic FORCED,
  output logic COMM_START,
  output logic COMM_STOP,
  output logic VAR_INIT,
  output logic PROG_RESTART,
  output logic PROG_HALT,
  output logic FORCE_CLEAR,
  output logic NVM_ERASE_PROG,
  output logic NVM_ERASE_APP,
  output logic RUN_LED,
  output logic DBG_LED
);

  // Mode code for readback
  function automatic logic [2:0] mode_code(input mode_e m);
    case (m)
      MODE_INIT: mode_code = `CODE_INIT;
      MODE_PROGRAM: mode_code = `CODE_PROGRAM;
      MODE_RUN: mode_code = `CODE_RUN;
      MODE_DBG_STOP: mode_code = `CODE_DBG_STOP;
      MODE_DBG_RUN: mode_code = `CODE_DBG_RUN;
      default: mode_code = `CODE_RESTORE;
    endcase
  endfunction

  // True for modes that exchange process data
  function automatic logic is_live(input mode_e m);
    is_live = (m == MODE_RUN) || (m == MODE_DBG_STOP) || (m == MODE_DBG_RUN);
  endfunction

  mode_e mode_reg;
  mode_e mode_next;
  logic [6:0] act_reg;
  logic [6:0] act_next;
  logic session_reg;
  logic session_next;
  logic refused_reg;
  logic refused_next;
  logic forced_reg;
  logic forced_next;
  logic reject_reg;
  logic reject_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic [15:0] sin_reg;
  logic [15:0] sin_next;
  logic [15:0] stdin_reg;
  logic [15:0] stdin_next;
  logic [15:0] sout_reg;
  logic [15:0] sout_next;
  logic [15:0] stdout_reg;
  logic [15:0] stdout_next;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic wr_stb;
  logic req_valid;
  logic [2:0] req_code;
  logic loss_expired;
  logic debug_mode;
  logic run_steady;
  logic run_flash;
  logic dbg_steady;
  logic dbg_flash;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: a write lands on the edge where the master sees ack
  assign wr_stb = WB_CYC_I & WB_STB_I & WB_WE_I & ack_reg & WB_SEL_I[0];
  assign req_valid = wr_stb && (WB_ADR_I == `ADR_MODE);
  assign req_code = WB_DAT_I[2:0];
  assign debug_mode = (mode_reg == MODE_DBG_STOP) || (mode_reg == MODE_DBG_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // Mode state machine; act bits: start, stop, init, restart, halt, fclr, erase
  // No host controller mode input exists; only bus requests, self-test completion and the loss timer move the mode
  always_comb
  begin
    mode_next = mode_reg;
    act_next = 7'h00;
    case (mode_reg)
      MODE_INIT:
      begin
        if (SELFTEST_DONE && PROG_VALID)
        begin
          mode_next = MODE_RUN;
          act_next = 7'h0D;
        end
        else if (SELFTEST_DONE)
          mode_next = MODE_PROGRAM;
      end
      MODE_PROGRAM:
      begin
        if (req_valid && req_code == `CODE_DBG_STOP && session_reg)
        begin
          mode_next = MODE_DBG_STOP;
          act_next = 7'h01;
        end
        else if (req_valid && req_code == `CODE_RUN && PROG_VALID)
        begin
          mode_next = MODE_RUN;
          act_next = 7'h0D;
        end
        else if (req_valid && req_code == `CODE_RESTORE)
          mode_next = MODE_RESTORE;
      end
      MODE_RUN:
      begin
        if (req_valid && req_code == `CODE_PROGRAM)
        begin
          mode_next = MODE_PROGRAM;
          act_next = 7'h56;
        end
      end
      MODE_DBG_STOP:
      begin
        if (loss_expired || (req_valid && req_code == `CODE_PROGRAM))
        begin
          mode_next = MODE_PROGRAM;
          act_next = 7'h02;
        end
        else if (req_valid && req_code == `CODE_DBG_RUN)
        begin
          mode_next = MODE_DBG_RUN;
          act_next = 7'h0C;
        end
      end
      MODE_DBG_RUN:
      begin
        if (loss_expired || (req_valid && req_code == `CODE_PROGRAM))
        begin
          mode_next = MODE_PROGRAM;
          act_next = 7'h36;
        end
        else if (req_valid && req_code == `CODE_DBG_STOP)
        begin
          mode_next = MODE_DBG_STOP;
          act_next = 7'h34;
        end
      end
      MODE_RESTORE:
      begin
        if (req_valid && req_code == `CODE_PROGRAM)
          mode_next = MODE_PROGRAM;
      end
      default:
        mode_next = MODE_INIT;
    endcase
    // Any other request code falls through above untouched
    if (mode_reg == MODE_PROGRAM && mode_next == MODE_DBG_STOP)
      act_next[6] = 1'b1;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      mode_reg <= MODE_INIT;
      act_reg <= 7'h00;
    end
    else
    begin
      mode_reg <= mode_next;
      act_reg <= act_next;
    end
  end

  // Action pulses, registered on the same edge as the mode change
  assign COMM_START = act_reg[0];
  assign COMM_STOP = act_reg[1];
  assign VAR_INIT = act_reg[2];
  assign PROG_RESTART = act_reg[3];
  assign PROG_HALT = act_reg[4];
  assign FORCE_CLEAR = act_reg[5];
  assign NVM_ERASE_PROG = act_reg[6] & (mode_reg == MODE_PROGRAM) & ~act_reg[0];
  assign NVM_ERASE_APP = act_reg[6] & (mode_reg == MODE_DBG_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // Tool session: one owner at a time, dropped when the link goes down
  always_comb
  begin
    session_next = session_reg;
    refused_next = refused_reg;
    if (wr_stb && WB_ADR_I == `ADR_STATUS && WB_DAT_I[`ST_CLR_REFUSED_BIT])
      refused_next = 1'b0;
    if (wr_stb && WB_ADR_I == `ADR_SESSION && WB_DAT_I[`SES_CLOSE_BIT])
      session_next = 1'b0;
    else if (wr_stb && WB_ADR_I == `ADR_SESSION && WB_DAT_I[`SES_OPEN_BIT])
    begin
      if (session_reg)
        refused_next = 1'b1;
      else if (TOOL_LINK)
        session_next = 1'b1;
    end
    if (!TOOL_LINK)
      session_next = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      session_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      session_reg <= session_next;
      refused_reg <= refused_next;
    end
  end

  // Fallback timer runs only while debug has no tool behind it
  loss_timer #(
    .LOSS_CYCLES(LOSS_CYCLES)
  ) u_loss (
    .clk(CLK),
    .srst(SRST),
    .arm(debug_mode & ~session_reg),
    .expired(loss_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Forced refreshing; a forced variable may never survive leaving debug
  always_comb
  begin
    forced_next = forced_reg;
    reject_next = reject_reg;
    if (wr_stb && WB_ADR_I == `ADR_STATUS && WB_DAT_I[`ST_CLR_REJECT_BIT])
      reject_next = 1'b0;
    if (wr_stb && WB_ADR_I == `ADR_FORCE)
    begin
      if (debug_mode)
        forced_next = WB_DAT_I[`FRC_REQ_BIT];
      else if (WB_DAT_I[`FRC_REQ_BIT])
        reject_next = 1'b1;
    end
    if (act_next[5] || !is_live(mode_next))
      forced_next = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      forced_reg <= 1'b0;
      reject_reg <= 1'b0;
    end
    else
    begin
      forced_reg <= forced_next;
      reject_reg <= reject_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Process data and status handling per mode
  always_comb
  begin
    sin_next = `IO_RESET;
    stdin_next = `IO_RESET;
    sout_next = `IO_RESET;
    stdout_next = `IO_RESET;
    status_next = `IO_RESET;
    if (is_live(mode_reg))
    begin
      sin_next = SAFE_IN;
      stdin_next = STD_IN;
      sout_next = PROG_SAFE_OUT;
      stdout_next = PROG_STD_OUT;
    end
    if (is_live(mode_reg) || mode_reg == MODE_PROGRAM)
    begin
      status_next = 16'h0000;
      status_next[2:0] = mode_code(mode_reg);
      status_next[`ST_COMM_BIT] = is_live(mode_reg);
      status_next[`ST_EXEC_BIT] = PROG_EXEC;
      status_next[`ST_RUNLED_BIT] = run_steady;
      status_next[`ST_DBGLED_BIT] = dbg_steady;
      status_next[`ST_LOSS_BIT] = debug_mode & ~session_reg;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      sin_reg <= `IO_RESET;
      stdin_reg <= `IO_RESET;
      sout_reg <= `IO_RESET;
      stdout_reg <= `IO_RESET;
      status_reg <= `IO_RESET;
    end
    else
    begin
      sin_reg <= sin_next;
      stdin_reg <= stdin_next;
      sout_reg <= sout_next;
      stdout_reg <= stdout_next;
      status_reg <= status_next;
    end
  end

  assign SAFE_IN_DATA = sin_reg;
  assign STD_IN_DATA = stdin_reg;
  assign SAFE_OUT = sout_reg;
  assign STD_OUT = stdout_reg;
  assign STATUS_WORD = status_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decoding for execution and indicators
  assign SELFTEST_RUN = (mode_reg == MODE_INIT);
  assign COMM_ACTIVE = is_live(mode_reg);
  assign PROG_EXEC = (mode_reg == MODE_RUN) || (mode_reg == MODE_DBG_RUN);
  assign FORCE_EN = debug_mode;
  assign FORCED = forced_reg;
  assign run_steady = PROG_EXEC;
  assign run_flash = (mode_reg == MODE_INIT) || (mode_reg == MODE_RESTORE);
  assign dbg_steady = debug_mode;
  assign dbg_flash = (mode_reg == MODE_RESTORE);

  indicator_drv #(
    .FLASH_CYCLES(FLASH_CYCLES)
  ) u_run_led (
    .clk(CLK),
    .srst(SRST),
    .steady(run_steady),
    .flash(run_flash),
    .led(RUN_LED)
  );

  indicator_drv #(
    .FLASH_CYCLES(FLASH_CYCLES)
  ) u_dbg_led (
    .clk(CLK),
    .srst(SRST),
    .steady(dbg_steady),
    .flash(dbg_flash),
    .led(DBG_LED)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the strobe, unmapped reads give zero
  always_comb
  begin
    ack_next = WB_CYC_I & WB_STB_I & ~ack_reg;
    dat_next = dat_reg;
    if (ack_next)
    begin
      dat_next = `DATA_RESET;
      case (WB_ADR_I)
        `ADR_MODE: dat_next[2:0] = mode_code(mode_reg);
        `ADR_SESSION:
        begin
          dat_next[`SES_OPEN_BIT] = session_reg;
          dat_next[`SES_REFUSED_BIT] = refused_reg;
        end
        `ADR_FORCE:
        begin
          dat_next[`FRC_REQ_BIT] = forced_reg;
          dat_next[`FRC_REJECT_BIT] = reject_reg;
        end
        `ADR_STATUS:
        begin
          dat_next[2:0] = mode_code(mode_reg);
          dat_next[`ST_COMM_BIT] = COMM_ACTIVE;
          dat_next[`ST_EXEC_BIT] = PROG_EXEC;
          dat_next[`ST_RUNLED_BIT] = RUN_LED;
          dat_next[`ST_DBGLED_BIT] = DBG_LED;
          dat_next[`ST_LOSS_BIT] = debug_mode & ~session_reg;
        end
        default: dat_next = `DATA_RESET;
      endcase
    end
  end

  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      ack_reg <= 1'b0;
      dat_reg <= `DATA_RESET;
    end
    else
    begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;
endmodule

// File: dv/safety_mode_ctrl_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the mode controller
module safety_mode_ctrl_assertions (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [15:0] SAFE_IN,
  input wire logic [15:0] SAFE_IN_DATA,
  input wire logic [15:0] SAFE_OUT,
  input wire logic [15:0] STD_IN,
  input wire logic [15:0] STD_IN_DATA,
  input wire logic SELFTEST_RUN,
  input wire logic COMM_ACTIVE,
  input wire logic PROG_EXEC,
  input wire logic FORCE_EN,
  input wire logic FORCED,
  input wire logic COMM_START,
  input wire logic COMM_STOP,
  input wire logic VAR_INIT,
  input wire logic PROG_RESTART,
  input wire logic PROG_HALT,
  input wire logic FORCE_CLEAR,
  input wire logic NVM_ERASE_PROG,
  input wire logic NVM_ERASE_APP,
  input wire logic RUN_LED,
  input wire logic DBG_LED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus request, answer and live data window
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  sequence s_live;
    COMM_ACTIVE ##1 COMM_ACTIVE;
  endsequence
  property p_ack;
    s_req |=> s_ack;
  endproperty
  property p_init;
    SELFTEST_RUN |-> !DBG_LED && !COMM_ACTIVE && !PROG_EXEC;
  endproperty
  // Two idle cycles allowed so the last live sample can drain
  property p_quiet;
    !COMM_ACTIVE [*2] |-> SAFE_IN_DATA == 16'h0000 && SAFE_OUT == 16'h0000;
  endproperty
  property p_refresh;
    s_live |-> SAFE_IN_DATA == $past(SAFE_IN);
  endproperty
  property p_leds;
    COMM_ACTIVE |-> RUN_LED == PROG_EXEC && DBG_LED == FORCE_EN;
  endproperty
  property p_start;
    COMM_START == $rose(COMM_ACTIVE);
  endproperty
  property p_stop;
    COMM_STOP == $fell(COMM_ACTIVE);
  endproperty
  property p_fclr;
    FORCE_CLEAR |-> $fell(PROG_EXEC) && $past(FORCE_EN);
  endproperty
  property p_erase_prog;
    NVM_ERASE_PROG |-> $fell(PROG_EXEC) && !$past(FORCE_EN) && !COMM_ACTIVE;
  endproperty
  property p_erase_app;
    NVM_ERASE_APP |-> $rose(FORCE_EN) && !PROG_EXEC;
  endproperty
  property p_force;
    !FORCE_EN [*3] |-> !FORCED;
  endproperty
  // Standard inputs follow the same one-cycle refresh as the safety inputs
  property p_std_refresh;
    s_live |-> STD_IN_DATA == $past(STD_IN);
  endproperty
  // Every program start and stop comes with its pulse, and only then
  property p_restart;
    PROG_RESTART == $rose(PROG_EXEC);
  endproperty
  property p_halt;
    PROG_HALT == $fell(PROG_EXEC);
  endproperty
  // Variables are initialized exactly when execution starts or stops
  property p_var_init;
    VAR_INIT == $changed(PROG_EXEC);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
  a_init: assert property (p_init) else $error("init outputs wrong");
  a_quiet: assert property (p_quiet) else $error("idle data not zero");
  a_refresh: assert property (p_refresh) else $error("input not refreshed");
  a_leds: assert property (p_leds) else $error("live indicators wrong");
  a_start: assert property (p_start) else $error("start pulse wrong");
  a_stop: assert property (p_stop) else $error("stop pulse wrong");
  a_fclr: assert property (p_fclr) else $error("force clear wrong");
  a_erase_prog: assert property (p_erase_prog) else $error("program erase wrong");
  a_erase_app: assert property (p_erase_app) else $error("app erase wrong");
  a_force: assert property (p_force) else $error("forced outside debug");
  a_std_refresh: assert property (p_std_refresh) else $error("std input stale");
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  a_halt: assert property (p_halt) else $error("halt pulse wrong");
  a_var_init: assert property (p_var_init) else $error("var init wrong");
endmodule
bind safety_mode_ctrl safety_mode_ctrl_assertions u_chk (.CLK(CLK), .SRST(SRST),
  .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .SAFE_IN(SAFE_IN),
  .SAFE_IN_DATA(SAFE_IN_DATA), .SAFE_OUT(SAFE_OUT), .STD_IN(STD_IN),
  .STD_IN_DATA(STD_IN_DATA), .SELFTEST_RUN(SELFTEST_RUN),
  .COMM_ACTIVE(COMM_ACTIVE), .PROG_EXEC(PROG_EXEC), .FORCE_EN(FORCE_EN), .FORCED(FORCED),
  .COMM_START(COMM_START), .COMM_STOP(COMM_STOP), .VAR_INIT(VAR_INIT),
  .PROG_RESTART(PROG_RESTART), .PROG_HALT(PROG_HALT), .FORCE_CLEAR(FORCE_CLEAR),
  .NVM_ERASE_PROG(NVM_ERASE_PROG), .NVM_ERASE_APP(NVM_ERASE_APP), .RUN_LED(RUN_LED),
  .DBG_LED(DBG_LED));

// File: dv/far_side_model.sv
`timescale 1ns/1ps
// Tool session line and remote input units
module far_side_model (
  input wire logic clk,
  input wire logic link_req,
  output logic tool_link,
  output logic [15:0] safe_in,
  output logic [15:0] std_in
);
  logic link_reg = 1'b0;
  logic [15:0] seq_reg = 16'h1357;
  // Tool only goes online when asked; unit data moves every cycle so stale samples show
  always_ff @(posedge clk)
  begin
    link_reg <= link_req;
    seq_reg <= seq_reg + 16'h0F11;
  end
  assign tool_link = link_reg;
  assign safe_in = seq_reg;
  assign std_in = ~seq_reg;
endmodule

// File: dv/safety_mode_ctrl_tb.sv
`timescale 1ns/1ps
`include "mode_defs.svh"
module safety_mode_ctrl_tb;
  localparam int LOSS = 50;
  localparam int FLASH = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, link_req = 1'b0, st_done = 1'b0;
  logic prog_valid = 1'b0;
  logic [15:0] p_safe = 16'hA5C3, p_std = 16'h3C5A;
  logic [31:0] rdat, dat_o;
  logic ack, tool_link, st_run, comm, exec, f_en, forced, run_led, dbg_led;
  logic [15:0] s_in, t_in, s_in_d, t_in_d, s_out, t_out, status;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Design, far side and clock
  safety_mode_ctrl #(.LOSS_CYCLES(LOSS), .FLASH_CYCLES(FLASH)) uut (
    .CLK(clk), .SRST(srst), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
    .WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
    .TOOL_LINK(tool_link), .SELFTEST_DONE(st_done), .PROG_VALID(prog_valid),
    .SAFE_IN(s_in), .STD_IN(t_in), .PROG_SAFE_OUT(p_safe), .PROG_STD_OUT(p_std),
    .SAFE_IN_DATA(s_in_d), .STD_IN_DATA(t_in_d), .SAFE_OUT(s_out), .STD_OUT(t_out),
    .STATUS_WORD(status), .SELFTEST_RUN(st_run), .COMM_ACTIVE(comm), .PROG_EXEC(exec),
    .FORCE_EN(f_en), .FORCED(forced), .COMM_START(), .COMM_STOP(), .VAR_INIT(),
    .PROG_RESTART(), .PROG_HALT(), .FORCE_CLEAR(), .NVM_ERASE_PROG(), .NVM_ERASE_APP(),
    .RUN_LED(run_led), .DBG_LED(dbg_led));
  far_side_model far (.clk(clk), .link_req(link_req), .tool_link(tool_link),
    .safe_in(s_in), .std_in(t_in));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic report_and_stop();
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Classic single cycle; held until ack is sampled, then released for a cycle
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_mode(input logic [2:0] c);
    wb(`ADR_MODE, 1'b1, {29'h0, c});
    step(2);
  endtask
  task automatic mode_is(input logic [2:0] c);
    wb(`ADR_MODE, 1'b0, 32'h0);
    check("mode", rdat & 32'h7, {29'h0, c});
  endtask
  task automatic flags(input logic [2:0] e);
    check("dbg_comm_exec", {dbg_led, comm, exec}, e);
  endtask
  task automatic blink(input int er, input int ed);
    int hr = 0;
    int hd = 0;
    repeat (16)
    begin
      @(posedge clk);
      if (run_led === 1'b1) hr++;
      if (dbg_led === 1'b1) hd++;
    end
    check("run_blink", hr, er);
    check("dbg_blink", hd, ed);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Mode sequence
  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    step(2);
    check("init", {st_run, dbg_led, comm, exec}, 4'b1000);
    blink(8, 0);
    mode_is(`CODE_INIT);
    check("safe_out", s_out, 16'h0000);
    @(posedge clk);
    st_done <= 1'b1;
    step(3);
    mode_is(`CODE_PROGRAM);
    flags(3'b000);
    check("status", status[2:0], `CODE_PROGRAM);
    set_mode(`CODE_INIT);
    mode_is(`CODE_PROGRAM);
    set_mode(`CODE_DBG_RUN);
    mode_is(`CODE_PROGRAM);
    set_mode(`CODE_DBG_STOP);
    mode_is(`CODE_PROGRAM);
    wb(`ADR_FORCE, 1'b1, 32'h1);
    wb(`ADR_FORCE, 1'b0, 32'h0);
    check("force_reject", rdat[`FRC_REJECT_BIT], 1'b1);
    check("forced", forced, 1'b0);
    @(posedge clk);
    link_req <= 1'b1;
    step(3);
    wb(`ADR_SESSION, 1'b1, 32'h1);
    wb(`ADR_SESSION, 1'b1, 32'h1);
    wb(`ADR_SESSION, 1'b0, 32'h0);
    check("second_session", rdat[`SES_REFUSED_BIT], 1'b1);
    set_mode(`CODE_DBG_STOP);
    mode_is(`CODE_DBG_STOP);
    flags(3'b110);
    check("run_led", run_led, 1'b0);
    set_mode(`CODE_DBG_RUN);
    mode_is(`CODE_DBG_RUN);
    flags(3'b111);
    check("safe_out", s_out, p_safe);
    check("std_out", t_out, p_std);
    wb(`ADR_FORCE, 1'b1, 32'h1);
    step(1);
    check("forced", forced, 1'b1);
    set_mode(`CODE_DBG_STOP);
    step(1);
    check("forced", forced, 1'b0);
    flags(3'b110);
    // Session loss: still in debug short of the limit, back in program after it
    @(posedge clk);
    link_req <= 1'b0;
    step(LOSS - 10);
    mode_is(`CODE_DBG_STOP);
    step(20);
    mode_is(`CODE_PROGRAM);
    check("safe_in_data", s_in_d, 16'h0000);
    @(posedge clk);
    prog_valid <= 1'b1;
    set_mode(`CODE_RUN);
    mode_is(`CODE_RUN);
    flags(3'b011);
    check("run_led", run_led, 1'b1);
    check("std_out", t_out, p_std);
    set_mode(`CODE_PROGRAM);
    mode_is(`CODE_PROGRAM);
    check("safe_out", s_out, 16'h0000);
    set_mode(`CODE_RESTORE);
    mode_is(`CODE_RESTORE);
    check("comm_exec", {comm, exec}, 2'b00);
    blink(8, 8);
    check("status", status, 16'h0000);
    set_mode(`CODE_PROGRAM);
    mode_is(`CODE_PROGRAM);
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    step(4);
    mode_is(`CODE_RUN);
    report_and_stop();
  end
endmodule
